// ==== hdl/nebps_pkg.sv ====
// Purpose: shared constants and types of the narrow bus pin and strap block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: offsets are byte addresses
package nebps_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SPACE = 8'h04;
  localparam logic [7:0] OFF_ACCESS = 8'h08;
  localparam logic [7:0] OFF_STRAP = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam int CTRL_DIV_LSB = 0;
  localparam int CTRL_REN_LSB = 2;
  localparam logic [1:0] RST_DIV = 2'h0;
  localparam logic RST_REN = 1'b0;
  localparam logic [1:0] RST_BOOT = 2'h2;
  localparam logic RST_ENDIAN = 1'b1;
  localparam int STRAP_ENDIAN = 20;
  localparam int STRAP_BOOT_LSB = 18;
  localparam int STRAP_WIDE_LSB = 16;
  localparam int STRAP_NARROW_LSB = 14;
  localparam int STRAP_EEPROM_AUTO_INIT_STRAP = 13;
  localparam int STRAP_CELL = 11;
  localparam int SPACE_LSB = 26;
  // busy cycles before ready is looked at; covers the ready synchroniser delay
  localparam logic [3:0] ACCESS_WAIT = 4'h3;
  localparam logic [1:0] CLK_PIN = 2'h0;
  localparam logic [1:0] CLK_CPU4 = 2'h1;
  localparam logic [1:0] CLK_CPU6 = 2'h2;
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  typedef enum logic [1:0] {
    MEM_ASYNC = 2'h0,
    MEM_SDRAM = 2'h1,
    MEM_SYNC = 2'h2
  } nebps_mem_e;
  typedef struct packed {
    logic endianLittle;
    logic [1:0] bootMode;
    logic [1:0] wideBusClockSelect;
    logic [1:0] narrowBusClockSelect;
    logic eepromAutoInitStrap;
    logic cellPortEnableStrap;
  } nebps_strap_s;
  typedef struct packed {
    logic readStrobe;
    logic outputStrobe;
    logic writeStrobe;
    logic fifoOutputStrobeSpace3;
  } nebps_strobe_s;
endpackage

// ==== hdl/nebps_clkgen.sv ====
// Purpose: bus clock source select and output clock dividers
// Assumes: clock pin already synchronised; cpu clock is clk
// Notes: outputs toggle on clk edges, so rates are divided from clk
module nebps_clkgen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinLevel,
  input wire logic [1:0] sourceSelect,
  input wire logic [1:0] divideSelect,
  output logic busClockOutFull,
  output logic busClockOutDivided
);
  logic [2:0] cpuCount;
  logic cpu4Clock;
  logic cpu6Clock;
  logic srcClock;
  logic srcPrev;
  logic [1:0] divCount;
  logic next_srcClock;
  wire srcRise = srcClock & ~srcPrev;
  wire [2:0] cpuWrap = (sourceSelect == nebps_pkg::CLK_CPU6) ? 3'h5 : 3'h3;
  always_comb begin
    unique case (sourceSelect)
      nebps_pkg::CLK_CPU4: next_srcClock = cpu4Clock;
      nebps_pkg::CLK_CPU6: next_srcClock = cpu6Clock;
      default: next_srcClock = pinLevel;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuCount <= 3'h0;
      cpu4Clock <= 1'b0;
      cpu6Clock <= 1'b0;
    end else begin
      cpuCount <= (cpuCount >= cpuWrap) ? 3'h0 : cpuCount + 3'h1;
      cpu4Clock <= (cpuCount < 3'h2);
      cpu6Clock <= (cpuCount < 3'h3);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srcClock <= 1'b0;
      srcPrev <= 1'b0;
      divCount <= 2'h0;
      busClockOutFull <= 1'b0;
      busClockOutDivided <= 1'b0;
    end else begin
      srcClock <= next_srcClock;
      srcPrev <= srcClock;
      busClockOutFull <= srcClock;
      if (srcRise) begin
        divCount <= divCount + 2'h1;
      end
      unique case (divideSelect)
        nebps_pkg::DIV_BY2: busClockOutDivided <= srcRise ? divCount[0] : busClockOutDivided;
        nebps_pkg::DIV_BY4: busClockOutDivided <= srcRise ? divCount[1] : busClockOutDivided;
        default: busClockOutDivided <= srcClock;
      endcase
    end
  end
endmodule

// ==== hdl/nebps_top.sv ====
// Purpose: narrow external bus pin functions and reset strap capture
// Assumes: APB slave; straps sampled from address pins while in reset
// Notes: strobes are active low at the pins
// Notes on behaviour
// - divided output clock, divide by 1/2/4
// - full output clock equals selected source
// - read strobe pin shared by memory type
// - sync space: 0 address strobe, 1 read
// - output strobe pin shared by memory type
// - write strobe pin shared by memory type
// - dedicated fifo output strobe for space 3
// - async access waits on sampled ready
// - address pins carry half-word address
// - address pins are inputs during reset
// - strap bit 20 selects endianness
// - strap bits 19:18 select boot mode
// - strap bits 17:16 wide bus clock
// - strap bits 15:14 narrow bus clock
// - strap bit 13 eeprom auto init
// - strap bit 11 cell port enable
// - bits 26..31 decode one chip enable
//
// The address map and the APB slave port are this design's own decisions.
module nebps_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic busClockInPin,
  input wire logic asyncReadyIn,
  input wire logic [20:1] narrowBusAddressIn,
  output logic [20:1] narrowBusAddressOut,
  output logic narrowBusAddressOe,
  output logic [3:0] chipEnable_n,
  output logic readStrobe_n,
  output logic outputStrobe_n,
  output logic writeStrobe_n,
  output logic fifoOutputStrobeSpace3_n,
  output logic busClockOutFull,
  output logic busClockOutDivided,
  output logic endianLittle,
  output logic [1:0] bootMode,
  output logic [1:0] wideBusClockSelect,
  output logic eepromAutoInitStrap,
  output logic cellPortEnableStrap,
  output logic serialPortOneEnable
);
  logic [20:1] addrSync1;
  logic [20:1] addrSync2;
  logic [1:0] clkSync;
  logic [1:0] rdySync;
  logic strapDone;
  nebps_pkg::nebps_strap_s strap;
  logic [1:0] divideSelect;
  logic readStrobeSelect;
  logic [31:0] accessAddr;
  logic accessWrite;
  logic accessGo;
  logic accessBusy;
  logic [1:0] spaceType [4];
  // address pin capture runs in reset too, so the straps are settled at release
  always_ff @(posedge clk) begin
    addrSync1 <= narrowBusAddressIn;
    addrSync2 <= addrSync1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync <= 2'h0;
      rdySync <= 2'h0;
    end else begin
      clkSync <= {clkSync[0], busClockInPin};
      rdySync <= {rdySync[0], asyncReadyIn};
    end
  end
  // first edge after release takes the straps, then holds them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapDone <= 1'b0;
      strap <= '{nebps_pkg::RST_ENDIAN, nebps_pkg::RST_BOOT, nebps_pkg::CLK_PIN,
                 nebps_pkg::CLK_PIN, 1'b0, 1'b0};
    end else if (!strapDone) begin
      strapDone <= 1'b1;
      strap.endianLittle <= addrSync2[nebps_pkg::STRAP_ENDIAN];
      strap.bootMode <= addrSync2[nebps_pkg::STRAP_BOOT_LSB +: 2];
      strap.wideBusClockSelect <= addrSync2[nebps_pkg::STRAP_WIDE_LSB +: 2];
      strap.narrowBusClockSelect <= addrSync2[nebps_pkg::STRAP_NARROW_LSB +: 2];
      strap.eepromAutoInitStrap <= addrSync2[nebps_pkg::STRAP_EEPROM_AUTO_INIT_STRAP];
      strap.cellPortEnableStrap <= addrSync2[nebps_pkg::STRAP_CELL];
    end
  end
  // apb decode
  wire apbWrite = psel & penable & pwrite;
  wire apbRead = psel & ~penable & ~pwrite;
  wire [7:0] offset = paddr[7:0];
  wire hitMap = (offset == nebps_pkg::OFF_CTRL) | (offset == nebps_pkg::OFF_SPACE) |
                (offset == nebps_pkg::OFF_ACCESS) | (offset == nebps_pkg::OFF_STRAP) |
                (offset == nebps_pkg::OFF_STATUS);
  wire mapped = hitMap & (paddr[31:8] == 24'h0);
  wire [31:0] strapWord = {11'h0, strap.endianLittle, strap.bootMode,
                           strap.wideBusClockSelect, strap.narrowBusClockSelect,
                           strap.eepromAutoInitStrap, 1'b0, strap.cellPortEnableStrap, 11'h0};
  logic [31:0] readValue;
  always_comb begin
    unique case (offset)
      nebps_pkg::OFF_CTRL: readValue = {29'h0, readStrobeSelect, divideSelect};
      nebps_pkg::OFF_SPACE: readValue = {24'h0, spaceType[3], spaceType[2], spaceType[1],
                                        spaceType[0]};
      nebps_pkg::OFF_ACCESS: readValue = accessAddr;
      nebps_pkg::OFF_STRAP: readValue = strapWord;
      nebps_pkg::OFF_STATUS: readValue = {30'h0, rdySync[1], accessBusy};
      default: readValue = 32'h0;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (apbRead) begin
        prdata <= mapped ? readValue : 32'h0;
      end
    end
  end
  wire takeWrite = apbWrite & pready & mapped;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divideSelect <= nebps_pkg::RST_DIV;
      readStrobeSelect <= nebps_pkg::RST_REN;
      accessAddr <= 32'h0;
      accessWrite <= 1'b0;
      accessGo <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        spaceType[i] <= nebps_pkg::MEM_ASYNC;
      end
    end else begin
      accessGo <= 1'b0;
      if (takeWrite && offset == nebps_pkg::OFF_CTRL) begin
        divideSelect <= pwdata[nebps_pkg::CTRL_DIV_LSB +: 2];
        readStrobeSelect <= pwdata[nebps_pkg::CTRL_REN_LSB];
      end
      if (takeWrite && offset == nebps_pkg::OFF_SPACE) begin
        for (int i = 0; i < 4; i++) begin
          spaceType[i] <= pwdata[2*i +: 2];
        end
      end
      if (takeWrite && offset == nebps_pkg::OFF_ACCESS && !accessBusy) begin
        accessAddr <= pwdata;
        accessWrite <= pwdata[0];
        accessGo <= 1'b1;
      end
    end
  end
  // space decode from word address bits 26..31, one enable at most
  wire [5:0] spaceField = accessAddr[nebps_pkg::SPACE_LSB +: 6];
  wire [1:0] spaceIdx = spaceField[1:0];
  wire spaceValid = (spaceField[5:2] == 4'h0);
  wire [1:0] curType = spaceType[spaceIdx];
  wire isAsync = curType == nebps_pkg::MEM_ASYNC;
  wire isSync = curType == nebps_pkg::MEM_SYNC;
  logic [3:0] waitCount;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accessBusy <= 1'b0;
      waitCount <= 4'h0;
    end else if (accessGo && spaceValid) begin
      accessBusy <= 1'b1;
      waitCount <= nebps_pkg::ACCESS_WAIT;
    end else if (accessBusy) begin
      if (waitCount != 4'h0) begin
        waitCount <= waitCount - 4'h1;
      end else if (!isAsync || rdySync[1]) begin
        accessBusy <= 1'b0;
      end
    end
  end
  nebps_pkg::nebps_strobe_s next_strobe;
  always_comb begin
    next_strobe = '0;
    if (accessBusy) begin
      // one pin per role, selected by space type
      next_strobe.readStrobe = ~accessWrite & (~isSync | readStrobeSelect);
      next_strobe.outputStrobe = ~accessWrite;
      next_strobe.writeStrobe = accessWrite;
      if (isSync && !readStrobeSelect) begin
        next_strobe.readStrobe = 1'b0;
      end
      next_strobe.fifoOutputStrobeSpace3 = isSync & (spaceIdx == 2'h3) & ~accessWrite;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      narrowBusAddressOut <= 20'h0;
      narrowBusAddressOe <= 1'b1;
      chipEnable_n <= 4'hF;
      readStrobe_n <= 1'b1;
      outputStrobe_n <= 1'b1;
      writeStrobe_n <= 1'b1;
      fifoOutputStrobeSpace3_n <= 1'b1;
    end else begin
      narrowBusAddressOe <= ~strapDone;
      narrowBusAddressOut <= accessAddr[20:1];
      for (int i = 0; i < 4; i++) begin
        chipEnable_n[i] <= ~(accessBusy & spaceValid & (spaceIdx == i[1:0]));
      end
      readStrobe_n <= ~next_strobe.readStrobe;
      outputStrobe_n <= ~next_strobe.outputStrobe;
      writeStrobe_n <= ~next_strobe.writeStrobe;
      fifoOutputStrobeSpace3_n <= ~next_strobe.fifoOutputStrobeSpace3;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      endianLittle <= nebps_pkg::RST_ENDIAN;
      bootMode <= nebps_pkg::RST_BOOT;
      wideBusClockSelect <= nebps_pkg::CLK_PIN;
      eepromAutoInitStrap <= 1'b0;
      cellPortEnableStrap <= 1'b0;
      serialPortOneEnable <= 1'b1;
    end else begin
      endianLittle <= strap.endianLittle;
      bootMode <= strap.bootMode;
      wideBusClockSelect <= strap.wideBusClockSelect;
      eepromAutoInitStrap <= strap.eepromAutoInitStrap;
      cellPortEnableStrap <= strap.cellPortEnableStrap;
      serialPortOneEnable <= ~strap.cellPortEnableStrap;
    end
  end
  nebps_clkgen clkGen (
    .clk(clk),
    .rst_n(rst_n),
    .pinLevel(clkSync[1]),
    .sourceSelect(strap.narrowBusClockSelect),
    .divideSelect(divideSelect),
    .busClockOutFull(busClockOutFull),
    .busClockOutDivided(busClockOutDivided)
  );
  AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    strapDone |=> $stable(strap)) else $error("straps changed after capture");
  AST_ONE_CE: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0(~chipEnable_n)) else $error("more than one chip enable");
  AST_ADDR_OE: assert property (@(posedge clk) disable iff (!rst_n)
    strapDone |=> !narrowBusAddressOe) else $error("address pins not driven");
  AST_CELL: assert property (@(posedge clk) disable iff (!rst_n)
    strapDone |=> ##1 (serialPortOneEnable != strap.cellPortEnableStrap))
    else $error("serial port one and cell port both on");
  AST_SYNC_ADS: assert property (@(posedge clk) disable iff (!rst_n)
    accessBusy && isSync && !readStrobeSelect |=> readStrobe_n)
    else $error("sync address strobe mode drives read");
  AST_READY: assert property (@(posedge clk) disable iff (!rst_n)
    accessBusy && isAsync && waitCount == 4'h0 && !rdySync[1] |=> accessBusy)
    else $error("async access ended without ready");
  AST_FIFO3: assert property (@(posedge clk) disable iff (!rst_n)
    !fifoOutputStrobeSpace3_n |-> !chipEnable_n[3])
    else $error("fifo strobe without space 3");
  AST_HALFWORD: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 narrowBusAddressOut == $past(accessAddr[20:1]))
    else $error("address pins not half-word");
  // an accepted start raises busy and then the addressed space enable
  sequence seqAccessStart;
    accessGo && spaceValid;
  endsequence
  sequence seqEnableFollows;
    accessBusy ##1 !(&chipEnable_n);
  endsequence
  AST_ACCESS_CE: assert property (@(posedge clk) disable iff (!rst_n)
    seqAccessStart |=> seqEnableFollows) else $error("no chip enable after start");
  AST_IDLE_STROBES: assert property (@(posedge clk) disable iff (!rst_n)
    !accessBusy |=> readStrobe_n && outputStrobe_n && writeStrobe_n &&
    fifoOutputStrobeSpace3_n) else $error("strobe active while idle");
  AST_ASYNC_READ: assert property (@(posedge clk) disable iff (!rst_n)
    accessBusy && !isSync && !accessWrite |=> !readStrobe_n)
    else $error("read strobe missing");
  AST_SYNC_RE: assert property (@(posedge clk) disable iff (!rst_n)
    accessBusy && isSync && readStrobeSelect && !accessWrite |=> !readStrobe_n)
    else $error("sync read enable missing");
  AST_READ_OE: assert property (@(posedge clk) disable iff (!rst_n)
    accessBusy && !accessWrite |=> !outputStrobe_n && writeStrobe_n)
    else $error("read access output strobe wrong");
  AST_WRITE_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
    accessBusy && accessWrite |=> !writeStrobe_n && readStrobe_n && outputStrobe_n)
    else $error("write access strobes wrong");
  AST_FIFO_READ: assert property (@(posedge clk) disable iff (!rst_n)
    !fifoOutputStrobeSpace3_n |-> !outputStrobe_n) else $error("fifo strobe outside a read");
  AST_ADDR_IN: assert property (@(posedge clk) disable iff (!rst_n)
    !strapDone |-> narrowBusAddressOe) else $error("address pins driven before capture");
  // the captured endian, boot and bus clock straps equal the pin levels seen at the capture edge
  AST_STRAP_ENDIAN: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strapDone) |-> strap.endianLittle == $past(addrSync2[nebps_pkg::STRAP_ENDIAN]))
    else $error("endian strap not captured");
  AST_STRAP_BOOT: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strapDone) |-> strap.bootMode == $past(addrSync2[nebps_pkg::STRAP_BOOT_LSB +: 2]))
    else $error("boot strap not captured");
  AST_STRAP_WIDE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strapDone) |->
      strap.wideBusClockSelect == $past(addrSync2[nebps_pkg::STRAP_WIDE_LSB +: 2]))
    else $error("wide clock strap not captured");
  AST_STRAP_NARROW: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strapDone) |->
      strap.narrowBusClockSelect == $past(addrSync2[nebps_pkg::STRAP_NARROW_LSB +: 2]))
    else $error("narrow clock strap not captured");
endmodule

// ==== bench/nebps_board_model.sv ====
// Purpose: board straps and async memory ready for nebps_top
// Assumes: ready pin has a pull-up when no memory drives it
// Notes: a selected memory holds ready low for readyDelay cycles
module nebps_board_model (
  input wire logic clk,
  input wire logic [20:1] strapLevels,
  input wire logic [7:0] readyDelay,
  input wire logic narrowBusAddressOe,
  input wire logic [20:1] narrowBusAddressOut,
  input wire logic [3:0] chipEnable_n,
  output logic [20:1] narrowBusAddressIn,
  output logic asyncReadyIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] waitCount = 8'h00;
  // resistors set the pins only while the device lets them float
  assign narrowBusAddressIn = narrowBusAddressOe ? strapLevels : narrowBusAddressOut;
  always @(posedge clk) begin
    if (&chipEnable_n) waitCount <= 8'h00;
    else if (waitCount != 8'hFF) waitCount <= waitCount + 8'h01;
  end
  assign asyncReadyIn = (&chipEnable_n) || (waitCount >= readyDelay);
endmodule

// ==== bench/tb.sv ====
// Purpose: self-checking bench for nebps_top
// Assumes: board model supplies strap levels and ready
// Notes: random straps and accesses from a fixed seed
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic busClockInPin = 1'b0;
  logic [2:0] pinCount = 3'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [20:1] straps = 20'h0;
  logic [7:0] readyDelay = 8'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, asyncReadyIn, narrowBusAddressOe, er;
  logic [20:1] narrowBusAddressIn, narrowBusAddressOut;
  logic [3:0] chipEnable_n;
  logic readStrobe_n, outputStrobe_n, writeStrobe_n, fifoOutputStrobeSpace3_n;
  logic busClockOutFull, busClockOutDivided, endianLittle, eepromAutoInitStrap;
  logic cellPortEnableStrap, serialPortOneEnable;
  logic [1:0] bootMode, wideBusClockSelect;
  int num_errors = 0;
  int num_checks = 0;
  int seed;
  logic [31:0] r;
  nebps_top u_nebps_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .busClockInPin, .asyncReadyIn, .narrowBusAddressIn,
    .narrowBusAddressOut, .narrowBusAddressOe, .chipEnable_n, .readStrobe_n,
    .outputStrobe_n, .writeStrobe_n, .fifoOutputStrobeSpace3_n, .busClockOutFull,
    .busClockOutDivided, .endianLittle, .bootMode, .wideBusClockSelect,
    .eepromAutoInitStrap, .cellPortEnableStrap, .serialPortOneEnable);
  nebps_board_model u_nebps_board_model (.clk, .strapLevels(straps), .readyDelay,
    .narrowBusAddressOe, .narrowBusAddressOut, .chipEnable_n, .narrowBusAddressIn,
    .asyncReadyIn);
  always #2 clk = ~clk;
  // pin clock period is 12 cycles of clk
  always @(posedge clk) begin
    pinCount <= (pinCount == 3'h5) ? 3'h0 : pinCount + 3'h1;
    if (pinCount == 3'h5) busClockInPin <= ~busClockInPin;
  end
  task close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  function automatic logic [31:0] near(input int a, input int b);
    return {31'h0, (a - b <= 1) && (b - a <= 1)};
  endfunction
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      chk("apb_wait", 32'h0, 32'h1);
      close_out;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task do_reset(input logic [20:1] s);
    @(posedge clk);
    rst_n <= 1'b0;
    straps <= s;
    repeat (4) @(posedge clk);
    chk("oe_in_reset", 32'h1, {31'h0, narrowBusAddressOe});
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("oe_running", 32'h0, {31'h0, narrowBusAddressOe});
    straps <= ~s;
    repeat (3) @(posedge clk);
    chk("strap_outs", {24'h0, s[20], s[19:18], s[17:16], s[13], s[11], ~s[11]},
      {24'h0, endianLittle, bootMode, wideBusClockSelect, eepromAutoInitStrap,
      cellPortEnableStrap, serialPortOneEnable});
    apb(1'b0, nebps_pkg::OFF_STRAP, 32'h0);
    chk("strap_reg", {11'h0, s, 1'b0} & 32'h001FE800, rd);
  endtask
  task clk_rate(input logic [1:0] src);
    int full, divd, base;
    logic pf, pd;
    base = (src == 2'h0) ? 20 : ((src == 2'h1) ? 60 : 40);
    for (int dv = 0; dv < 3; dv++) begin
      apb(1'b1, nebps_pkg::OFF_CTRL, dv);
      repeat (8) @(posedge clk);
      full = 0;
      divd = 0;
      pf = busClockOutFull;
      pd = busClockOutDivided;
      repeat (240) begin
        @(posedge clk);
        full += int'(busClockOutFull && !pf);
        divd += int'(busClockOutDivided && !pd);
        pf = busClockOutFull;
        pd = busClockOutDivided;
      end
      chk("full_clock_edges", 32'h1, near(full, base));
      chk("div_clock_edges", 32'h1, near(divd, base >> dv));
    end
  endtask
  task access(input logic [5:0] sp, input logic wr, input logic [1:0] ty, input logic ren);
    logic [31:0] d;
    logic [3:0] seen;
    logic bad;
    int ce, n;
    apb(1'b1, nebps_pkg::OFF_SPACE, {24'h0, {4{ty}}});
    apb(1'b1, nebps_pkg::OFF_CTRL, {29'h0, ren, 2'h0});
    d = {sp, 26'($random(seed))};
    d[0] = wr;
    apb(1'b1, nebps_pkg::OFF_ACCESS, d);
    ce = 0;
    n = 0;
    seen = 4'h0;
    bad = 1'b0;
    while (n < 300 && !(ce > 0 && (&chipEnable_n)) && !(sp > 6'h3 && n == 40)) begin
      @(posedge clk);
      n++;
      if (!(&chipEnable_n)) begin
        ce++;
        if (chipEnable_n !== ~(4'h1 << sp[1:0])) bad = 1'b1;
        if (narrowBusAddressOut !== d[20:1]) bad = 1'b1;
      end
      seen |= {~readStrobe_n, ~writeStrobe_n, ~fifoOutputStrobeSpace3_n, ~outputStrobe_n};
    end
    if (n == 300) begin
      chk("access_wait", 32'h0, 32'h1);
      close_out;
    end
    chk("ce_active", {31'h0, sp < 6'h4}, {31'h0, ce > 0});
    chk("ce_addr_bad", 32'h0, {31'h0, bad});
    if (sp < 6'h4) begin
      chk("write_strobe", {31'h0, wr}, {31'h0, seen[2]});
      chk("fifo_strobe", {31'h0, sp == 6'h3 && ty == nebps_pkg::MEM_SYNC && !wr},
        {31'h0, seen[1]});
      if (!wr && ty != nebps_pkg::MEM_SDRAM) begin
        chk("read_strobe", {31'h0, !(ty == nebps_pkg::MEM_SYNC && !ren)},
          {31'h0, seen[3]});
        chk("output_strobe", 32'h1, {31'h0, seen[0]});
      end
      if (ty == nebps_pkg::MEM_ASYNC) chk("ready_wait", 32'h1, {31'h0, ce >= readyDelay});
    end
  endtask
  initial begin
    seed = 32'hD9CB3B40;
    do_reset(20'h00000);
    do_reset(20'hFFFFF);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      r[15:14] = 2'(i);
      do_reset(r[20:1]);
      clk_rate(2'(i));
    end
    $display("test straps and clocks done");
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    readyDelay <= 8'h0C;
    access(6'h03, 1'b0, nebps_pkg::MEM_SYNC, 1'b1);
    access(6'h03, 1'b0, nebps_pkg::MEM_SYNC, 1'b0);
    access(6'h02, 1'b0, nebps_pkg::MEM_SYNC, 1'b1);
    access(6'h00, 1'b0, nebps_pkg::MEM_ASYNC, 1'b0);
    access(6'h01, 1'b1, nebps_pkg::MEM_ASYNC, 1'b0);
    access(6'h10, 1'b0, nebps_pkg::MEM_ASYNC, 1'b0);
    repeat (16) begin
      r = $random(seed);
      readyDelay <= {4'h0, r[13:10]};
      access({(r[9:8] == 2'h3) ? 4'h4 : 4'h0, r[1:0]}, r[2],
        (r[4:3] == 2'h3) ? 2'h0 : r[4:3], r[5]);
    end
    $display("test accesses done");
    close_out;
  end
endmodule
